/* hdl/bfro_pkg.sv */
// Purpose: Shared constants and types for the bidirectional queue reset and offset block
// Assumes: 1,024-word variant, 36-bit words, one system clock at 20 MHz
// Notes: Port clocks and all pins are sampled inputs, not clock domains
package bfro_pkg;

  // ==========================================================
  // Sizes
  localparam int DATA_W = 36;
  localparam int ADDR_W = 10;
  localparam int PTR_W = 11;
  localparam int OFS_W = 10;
  localparam logic [10:0] DEPTH = 11'h400;

  // ==========================================================
  // Offsets and counts
  localparam logic [9:0] PRESET_64 = 10'h040;
  localparam logic [9:0] PRESET_16 = 10'h010;
  localparam logic [9:0] PRESET_8 = 10'h008;
  localparam logic [9:0] OFS_RST = 10'h040;
  localparam logic [1:0] FS_64 = 2'h3;
  localparam logic [1:0] FS_16 = 2'h2;
  localparam logic [1:0] FS_8 = 2'h1;
  localparam logic [1:0] FS_PROG = 2'h0;
  localparam logic [1:0] IR_DELAY = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    BFRO_NORMAL = 5'h01,
    BFRO_LOAD_Y1 = 5'h02,
    BFRO_LOAD_X1 = 5'h04,
    BFRO_LOAD_Y2 = 5'h08,
    BFRO_LOAD_X2 = 5'h10
  } bfro_mode_t;

  typedef struct packed {
    logic cs_n;
    logic wr_sel;
    logic en;
    logic mb_sel;
  } bfro_ctrl_t;

  // Port controls at rest: chip select released
  localparam bfro_ctrl_t CTRL_IDLE = 4'h8;

  typedef struct packed {
    logic clk_a;
    logic clk_b;
    logic [1:0] rst_n;
    logic [1:0] fs;
    bfro_ctrl_t ctrl_a;
    bfro_ctrl_t ctrl_b;
    logic [35:0] data_a;
    logic [35:0] data_b;
  } bfro_pins_t;

endpackage

/* hdl/bfro_mem.sv */
// Purpose: Queue storage array with registered read data
// Assumes: One write and one read port on the system clock
// Notes: Array itself is not reset
`timescale 1ns/100ps
module bfro_mem (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_wr_en,
  input wire logic [bfro_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [bfro_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [bfro_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [bfro_pkg::DATA_W-1:0] o_rd_data
);

  logic [bfro_pkg::DATA_W-1:0] mem [1024];

  // ==========================================================
  // Array write
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // ==========================================================
  // Output register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= 36'h0;
    end else if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule

/* hdl/bfro_top.sv */
// Purpose: Bidirectional two-queue block with reset, offset and mailbox control
// Assumes: Port clocks much slower than i_clk; pins held steady around port edges
// Notes: Every pin passes two flops; port edges are found on the synced clocks
`timescale 1ns/100ps
module bfro_top (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_porta_clock,
  input wire logic i_portb_clock,
  input wire logic i_fifo_one_reset_n,
  input wire logic i_fifo_two_reset_n,
  input wire logic i_flag_select_lo,
  input wire logic i_flag_select_hi,
  input wire logic i_porta_chip_select_n,
  input wire logic i_porta_write_read_sel,
  input wire logic i_porta_enable,
  input wire logic i_porta_mailbox_sel,
  input wire logic i_portb_chip_select_n,
  input wire logic i_portb_write_read_sel,
  input wire logic i_portb_enable,
  input wire logic i_portb_mailbox_sel,
  input wire logic [35:0] i_porta_data_bus,
  input wire logic [35:0] i_portb_data_bus,
  output logic [35:0] o_porta_data_bus,
  output logic o_porta_data_bus_oe,
  output logic [35:0] o_portb_data_bus,
  output logic o_portb_data_bus_oe,
  output logic o_porta_input_ready,
  output logic o_porta_output_ready,
  output logic o_porta_almost_empty_n,
  output logic o_porta_almost_full_n,
  output logic o_portb_input_ready,
  output logic o_portb_output_ready,
  output logic o_portb_almost_empty_n,
  output logic o_portb_almost_full_n,
  output logic o_mailbox_one_flag_n,
  output logic o_mailbox_two_flag_n
);

  // ==========================================================
  // Pin synchroniser
  bfro_pkg::bfro_pins_t pins_raw;
  bfro_pkg::bfro_pins_t sync1;
  bfro_pkg::bfro_pins_t sync2;
  logic clk_a_d;
  logic clk_b_d;
  logic [1:0] rst_d;

  assign pins_raw = '{clk_a: i_porta_clock, clk_b: i_portb_clock,
    rst_n: {i_fifo_two_reset_n, i_fifo_one_reset_n},
    fs: {i_flag_select_hi, i_flag_select_lo},
    ctrl_a: '{cs_n: i_porta_chip_select_n, wr_sel: i_porta_write_read_sel,
              en: i_porta_enable, mb_sel: i_porta_mailbox_sel},
    ctrl_b: '{cs_n: i_portb_chip_select_n, wr_sel: i_portb_write_read_sel,
              en: i_portb_enable, mb_sel: i_portb_mailbox_sel},
    data_a: i_porta_data_bus, data_b: i_portb_data_bus};

  // Two stages, then one delay stage for edges
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1 <= '{ctrl_a: bfro_pkg::CTRL_IDLE, ctrl_b: bfro_pkg::CTRL_IDLE, default: '0}; // No false select
      sync2 <= '{ctrl_a: bfro_pkg::CTRL_IDLE, ctrl_b: bfro_pkg::CTRL_IDLE, default: '0};
      clk_a_d <= 1'b0;
      clk_b_d <= 1'b0;
      rst_d <= 2'h0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      clk_a_d <= sync2.clk_a;
      clk_b_d <= sync2.clk_b;
      rst_d <= sync2.rst_n;
    end
  end

  // ==========================================================
  // Decoded port events
  logic a_edge;
  logic b_edge;
  logic [1:0] rst_ok;
  logic [1:0] rst_rise;
  bfro_pkg::bfro_ctrl_t ca;
  bfro_pkg::bfro_ctrl_t cb;
  logic [1:0] wr_edge;
  logic [1:0] rd_edge;
  logic [1:0] wr_cmd;
  logic [1:0] rd_cmd;
  logic [35:0] din [2];
  logic [35:0] rd_data [2];
  logic [1:0] ir;
  logic [1:0] orf;
  logic [1:0] ae_n;
  logic [1:0] af_n;
  logic [9:0] empty_ofs [2];
  logic [9:0] full_ofs [2];
  logic prog_busy;

  // Sampled clock edges and released resets
  assign a_edge = sync2.clk_a & ~clk_a_d;
  assign b_edge = sync2.clk_b & ~clk_b_d;
  assign rst_ok = sync2.rst_n;
  assign rst_rise = sync2.rst_n & ~rst_d;
  assign ca = sync2.ctrl_a;
  assign cb = sync2.ctrl_b;

  // Queue one written by A, read by B; queue two the reverse
  assign wr_edge = {b_edge, a_edge};
  assign rd_edge = {a_edge, b_edge};
  assign wr_cmd[0] = ~ca.cs_n & ca.wr_sel & ca.en & ~ca.mb_sel;
  assign wr_cmd[1] = ~cb.cs_n & ~cb.wr_sel & cb.en & ~cb.mb_sel;
  assign rd_cmd[0] = ~cb.cs_n & cb.wr_sel & cb.en & ~cb.mb_sel;
  assign rd_cmd[1] = ~ca.cs_n & ~ca.wr_sel & ca.en & ~ca.mb_sel;
  assign din[0] = sync2.data_a;
  assign din[1] = sync2.data_b;

  // ==========================================================
  // Offset registers and programming sequence
  bfro_pkg::bfro_mode_t mode;
  bfro_pkg::bfro_mode_t next_mode;
  logic [9:0] a_to_b_queue_empty_offset;
  logic [9:0] b_to_a_queue_empty_offset;
  logic [9:0] a_to_b_queue_full_offset;
  logic [9:0] b_to_a_queue_full_offset;
  logic [9:0] next_a_to_b_queue_empty_offset;
  logic [9:0] next_b_to_a_queue_empty_offset;
  logic [9:0] next_a_to_b_queue_full_offset;
  logic [9:0] next_b_to_a_queue_full_offset;
  logic [1:0] fs_latch;
  logic [1:0] next_fs_latch;
  logic [9:0] preset;
  logic prog_wr;

  assign prog_busy = (mode != bfro_pkg::BFRO_NORMAL);
  assign prog_wr = a_edge & wr_cmd[0] & ir[0] & prog_busy;

  // Select capture, preset load, programming entry and the four-write sequence
  always_comb begin
    next_mode = mode;
    next_fs_latch = fs_latch;
    next_a_to_b_queue_empty_offset = a_to_b_queue_empty_offset;
    next_b_to_a_queue_empty_offset = b_to_a_queue_empty_offset;
    next_a_to_b_queue_full_offset = a_to_b_queue_full_offset;
    next_b_to_a_queue_full_offset = b_to_a_queue_full_offset;
    if (|rst_rise) begin
      next_fs_latch = sync2.fs;
    end
    // Preset decode of the captured select pair
    case (next_fs_latch)
      bfro_pkg::FS_64: preset = bfro_pkg::PRESET_64;
      bfro_pkg::FS_16: preset = bfro_pkg::PRESET_16;
      bfro_pkg::FS_8: preset = bfro_pkg::PRESET_8;
      default: preset = bfro_pkg::PRESET_64;
    endcase
    if (rst_rise[0] && next_fs_latch != bfro_pkg::FS_PROG) begin
      next_a_to_b_queue_empty_offset = preset;
      next_a_to_b_queue_full_offset = preset;
      next_mode = bfro_pkg::BFRO_NORMAL;
    end
    if (rst_rise[1] && next_fs_latch != bfro_pkg::FS_PROG) begin
      next_b_to_a_queue_empty_offset = preset;
      next_b_to_a_queue_full_offset = preset;
      next_mode = bfro_pkg::BFRO_NORMAL;
    end
    if (rst_rise == 2'h3 && next_fs_latch == bfro_pkg::FS_PROG) begin
      next_mode = bfro_pkg::BFRO_LOAD_Y1;
    end else if (prog_wr) begin
      case (mode)
        bfro_pkg::BFRO_LOAD_Y1: begin
          next_a_to_b_queue_full_offset = din[0][9:0];
          next_mode = bfro_pkg::BFRO_LOAD_X1;
        end
        bfro_pkg::BFRO_LOAD_X1: begin
          next_a_to_b_queue_empty_offset = din[0][9:0];
          next_mode = bfro_pkg::BFRO_LOAD_Y2;
        end
        bfro_pkg::BFRO_LOAD_Y2: begin
          next_b_to_a_queue_full_offset = din[0][9:0];
          next_mode = bfro_pkg::BFRO_LOAD_X2;
        end
        bfro_pkg::BFRO_LOAD_X2: begin
          next_b_to_a_queue_empty_offset = din[0][9:0];
          next_mode = bfro_pkg::BFRO_NORMAL;
        end
        default: next_mode = bfro_pkg::BFRO_NORMAL;
      endcase
    end
  end

  // Offsets only change on reset release or programming writes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode <= bfro_pkg::BFRO_NORMAL;
      fs_latch <= 2'h0;
      a_to_b_queue_empty_offset <= bfro_pkg::OFS_RST;
      b_to_a_queue_empty_offset <= bfro_pkg::OFS_RST;
      a_to_b_queue_full_offset <= bfro_pkg::OFS_RST;
      b_to_a_queue_full_offset <= bfro_pkg::OFS_RST;
    end else begin
      mode <= next_mode;
      fs_latch <= next_fs_latch;
      a_to_b_queue_empty_offset <= next_a_to_b_queue_empty_offset;
      b_to_a_queue_empty_offset <= next_b_to_a_queue_empty_offset;
      a_to_b_queue_full_offset <= next_a_to_b_queue_full_offset;
      b_to_a_queue_full_offset <= next_b_to_a_queue_full_offset;
    end
  end

  // Index of each offset equals its queue number
  assign empty_ofs[0] = a_to_b_queue_empty_offset;
  assign empty_ofs[1] = b_to_a_queue_empty_offset;
  assign full_ofs[0] = a_to_b_queue_full_offset;
  assign full_ofs[1] = b_to_a_queue_full_offset;

  // ==========================================================
  // Per-queue pointers and flags
  genvar q;
  generate
    for (q = 0; q < 2; q++) begin : g_queue
      logic [10:0] wptr;
      logic [10:0] rptr;
      logic [10:0] next_wptr;
      logic [10:0] next_rptr;
      logic [1:0] ir_cnt;
      logic [1:0] next_ir_cnt;
      logic or_q;
      logic next_or_q;
      logic [10:0] count;
      logic full;
      logic empty;
      logic mem_wr;
      logic mem_rd;
      logic gate;

      assign count = wptr - rptr;
      assign full = (count == bfro_pkg::DEPTH);
      assign empty = (count == 11'h000);
      // Queue two waits for programming to finish
      assign gate = (q == 0) ? 1'b1 : ~prog_busy;
      assign ir[q] = rst_ok[q] & (ir_cnt == bfro_pkg::IR_DELAY) & ~full & gate;
      assign orf[q] = or_q;
      assign ae_n[q] = rst_ok[q] & (count > {1'b0, empty_ofs[q]});
      assign af_n[q] = ~rst_ok[q] | ((bfro_pkg::DEPTH - count) > {1'b0, full_ofs[q]});
      assign mem_wr = wr_edge[q] & wr_cmd[q] & ir[q] & ((q == 0) ? ~prog_busy : 1'b1);
      assign mem_rd = rd_edge[q] & rst_ok[q] & ~empty & (~or_q | rd_cmd[q]);

      // Pointer, ready count and output-ready update
      always_comb begin
        next_wptr = wptr;
        next_rptr = rptr;
        next_ir_cnt = ir_cnt;
        next_or_q = or_q;
        if (!rst_ok[q]) begin
          next_wptr = 11'h000;
          next_rptr = 11'h000;
          next_ir_cnt = 2'h0;
          next_or_q = 1'b0;
        end else begin
          if (wr_edge[q] && ir_cnt != bfro_pkg::IR_DELAY) begin
            next_ir_cnt = ir_cnt + 2'h1;
          end
          if (mem_wr) begin
            next_wptr = wptr + 11'h001;
          end
          if (mem_rd) begin
            next_rptr = rptr + 11'h001;
            next_or_q = 1'b1;
          end else if (rd_edge[q] && rd_cmd[q]) begin
            next_or_q = 1'b0;
          end
        end
      end

      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          wptr <= 11'h000;
          rptr <= 11'h000;
          ir_cnt <= 2'h0;
          or_q <= 1'b0;
        end else begin
          wptr <= next_wptr;
          rptr <= next_rptr;
          ir_cnt <= next_ir_cnt;
          or_q <= next_or_q;
        end
      end

      bfro_mem u_mem (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_wr_en(mem_wr),
        .i_wr_addr(wptr[9:0]),
        .i_wr_data(din[q]),
        .i_rd_en(mem_rd),
        .i_rd_addr(rptr[9:0]),
        .o_rd_data(rd_data[q])
      );
    end
  endgenerate

  // ==========================================================
  // Mailboxes
  logic [35:0] mail1;
  logic [35:0] mail2;
  logic [35:0] next_mail1;
  logic [35:0] next_mail2;
  logic mailbox_one_flag_n_n;
  logic mailbox_two_flag_n_n;
  logic next_mailbox_one_flag_n_n;
  logic next_mailbox_two_flag_n_n;
  logic mail1_wr;
  logic mail2_wr;
  logic mail1_rd;
  logic mail2_rd;

  assign mail1_wr = a_edge & ~ca.cs_n & ca.wr_sel & ca.en & ca.mb_sel;
  assign mail2_wr = b_edge & ~cb.cs_n & ~cb.wr_sel & cb.en & cb.mb_sel;
  assign mail1_rd = b_edge & ~cb.cs_n & cb.wr_sel & cb.en & cb.mb_sel;
  assign mail2_rd = a_edge & ~ca.cs_n & ~ca.wr_sel & ca.en & ca.mb_sel;

  // New mail wins over a read in the same cycle
  always_comb begin
    next_mail1 = mail1_wr ? din[0] : mail1;
    next_mail2 = mail2_wr ? din[1] : mail2;
    if (!rst_ok[0]) begin
      next_mailbox_one_flag_n_n = 1'b1;
    end else if (mail1_wr) begin
      next_mailbox_one_flag_n_n = 1'b0;
    end else if (mail1_rd) begin
      next_mailbox_one_flag_n_n = 1'b1;
    end else begin
      next_mailbox_one_flag_n_n = mailbox_one_flag_n_n;
    end
    if (!rst_ok[1]) begin
      next_mailbox_two_flag_n_n = 1'b1;
    end else if (mail2_wr) begin
      next_mailbox_two_flag_n_n = 1'b0;
    end else if (mail2_rd) begin
      next_mailbox_two_flag_n_n = 1'b1;
    end else begin
      next_mailbox_two_flag_n_n = mailbox_two_flag_n_n;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mail1 <= 36'h0;
      mail2 <= 36'h0;
      mailbox_one_flag_n_n <= 1'b1;
      mailbox_two_flag_n_n <= 1'b1;
    end else begin
      mail1 <= next_mail1;
      mail2 <= next_mail2;
      mailbox_one_flag_n_n <= next_mailbox_one_flag_n_n;
      mailbox_two_flag_n_n <= next_mailbox_two_flag_n_n;
    end
  end

  // ==========================================================
  // Data outputs and drive enables
  logic [35:0] next_a_data;
  logic [35:0] next_b_data;
  logic next_a_oe;
  logic next_b_oe;

  // Mailbox select picks the source with no port edge needed
  always_comb begin
    next_a_data = ca.mb_sel ? next_mail2 : rd_data[1];
    next_b_data = cb.mb_sel ? next_mail1 : rd_data[0];
    next_a_oe = ~ca.cs_n & ~ca.wr_sel;
    next_b_oe = ~cb.cs_n & cb.wr_sel;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_porta_data_bus <= 36'h0;
      o_portb_data_bus <= 36'h0;
      o_porta_data_bus_oe <= 1'b0;
      o_portb_data_bus_oe <= 1'b0;
    end else begin
      o_porta_data_bus <= next_a_data;
      o_portb_data_bus <= next_b_data;
      o_porta_data_bus_oe <= next_a_oe;
      o_portb_data_bus_oe <= next_b_oe;
    end
  end

  // ==========================================================
  // Flag outputs, reset forcing per queue
  assign o_porta_input_ready = ir[0];
  assign o_porta_output_ready = orf[1];
  assign o_porta_almost_empty_n = ae_n[1];
  assign o_porta_almost_full_n = af_n[0];
  assign o_portb_input_ready = ir[1];
  assign o_portb_output_ready = orf[0];
  assign o_portb_almost_empty_n = ae_n[0];
  assign o_portb_almost_full_n = af_n[1];
  assign o_mailbox_one_flag_n = mailbox_one_flag_n_n;
  assign o_mailbox_two_flag_n = mailbox_two_flag_n_n;

endmodule

/* verification/bfro_sva.sv */
// Purpose: Port checks for the queue reset, offset and mailbox block
// Assumes: One system clock, port pins sampled through two flops
// Notes: Windows allow for the synchroniser depth
`timescale 1ns/100ps
module bfro_sva (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_porta_clock,
  input wire logic i_portb_clock,
  input wire logic i_fifo_one_reset_n,
  input wire logic i_fifo_two_reset_n,
  input wire logic i_porta_chip_select_n,
  input wire logic i_porta_write_read_sel,
  input wire logic i_portb_chip_select_n,
  input wire logic i_portb_write_read_sel,
  input wire logic o_porta_data_bus_oe,
  input wire logic o_portb_data_bus_oe,
  input wire logic o_porta_input_ready,
  input wire logic o_portb_input_ready,
  input wire logic o_porta_almost_empty_n,
  input wire logic o_porta_almost_full_n,
  input wire logic o_portb_almost_empty_n,
  input wire logic o_portb_almost_full_n,
  input wire logic o_mailbox_one_flag_n,
  input wire logic o_mailbox_two_flag_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================================
  // Queue reset forcing and ready release
  a_rst_one_forces: assert property (
    (!i_fifo_one_reset_n)[*4] |-> !o_portb_almost_empty_n && o_porta_almost_full_n
    && o_mailbox_one_flag_n && !o_porta_input_ready) else $error("queue one reset flags wrong");
  a_rst_two_forces: assert property (
    (!i_fifo_two_reset_n)[*4] |-> !o_porta_almost_empty_n && o_portb_almost_full_n
    && o_mailbox_two_flag_n && !o_portb_input_ready) else $error("queue two reset flags wrong");
  a_ready_a_waits: assert property (
    o_porta_input_ready |-> $past(i_fifo_one_reset_n, 4)) else $error("port a ready too soon");
  a_ready_b_waits: assert property (
    o_portb_input_ready |-> $past(i_fifo_two_reset_n, 4)) else $error("port b ready too soon");
  // ==========================================================
  // Output drive control
  a_oe_a_on: assert property (
    (!i_porta_chip_select_n && !i_porta_write_read_sel)[*4] |-> o_porta_data_bus_oe)
    else $error("port a not driving");
  a_oe_a_off: assert property (
    (i_porta_chip_select_n || i_porta_write_read_sel)[*4] |-> !o_porta_data_bus_oe)
    else $error("port a driving");
  a_oe_b_on: assert property (
    (!i_portb_chip_select_n && i_portb_write_read_sel)[*4] |-> o_portb_data_bus_oe)
    else $error("port b not driving");
  a_oe_b_off: assert property (
    (i_portb_chip_select_n || !i_portb_write_read_sel)[*4] |-> !o_portb_data_bus_oe)
    else $error("port b driving");
  // ==========================================================
  // Mail flags fall only after the writer port edge
  a_mail_one_edge: assert property (
    $fell(o_mailbox_one_flag_n) |-> $past(i_porta_clock, 2) || $past(i_porta_clock, 3))
    else $error("mail one flag fell off a port a edge");
  a_mail_two_edge: assert property (
    $fell(o_mailbox_two_flag_n) |-> $past(i_portb_clock, 2) || $past(i_portb_clock, 3))
    else $error("mail two flag fell off a port b edge");
  c_mail_one: cover property ($fell(o_mailbox_one_flag_n));
  c_ready_b: cover property ($rose(o_portb_input_ready));
  c_oe_b: cover property ($rose(o_portb_data_bus_oe));
endmodule
bind bfro_top bfro_sva i_bfro_sva (.*);

/* verification/bfro_port_clk.sv */
// Purpose: Far-side controllers' free-running port clocks
// Assumes: Port clocks slow against the system clock
// Notes: Periods differ so the two phases drift
`timescale 1ns/100ps
module bfro_port_clk (
  input wire logic i_clk,
  output logic o_porta_clock,
  output logic o_portb_clock
);
  logic [3:0] cnt_a = 4'h0;
  logic [3:0] cnt_b = 4'h0;
  // Port A 8 and port B 10 system cycles a period
  always @(posedge i_clk) begin
    cnt_a <= (cnt_a == 4'h7) ? 4'h0 : cnt_a + 4'h1;
    cnt_b <= (cnt_b == 4'h9) ? 4'h0 : cnt_b + 4'h1;
  end
  assign o_porta_clock = cnt_a[2];
  assign o_portb_clock = cnt_b > 4'h4;
endmodule

/* verification/test_bidir_fifo_reset_offset_prog.sv */
// Purpose: Reset, offset programming, preset and mailbox tests
// Assumes: Port ops held four system cycles past the port edge
// Notes: Offsets seen through the almost flags
`timescale 1ns/100ps
module test_bidir_fifo_reset_offset_prog;
  localparam logic [3:0] OP_MB [2] = '{4'h7, 4'h3};
  localparam logic [35:0] OFS [4] = '{36'h0_0000_03fc, 36'h8_0000_0402, 36'h0_0000_0005, 36'h0_0000_0003};
  localparam logic [1:0] FSEL [3] = '{2'h3, 2'h2, 2'h1};
  localparam int PRE [3] = '{64, 16, 8};
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [1:0] rst_n = 2'h0;
  logic [1:0] fs = 2'h0;
  bfro_pkg::bfro_ctrl_t ctl [2] = '{4'h8, 4'h8};
  logic [35:0] din [2] = '{36'h0, 36'h0};
  logic [35:0] dout [2];
  logic oe [2];
  logic ir [2];
  logic mbf [2];
  logic pclk [2];
  logic aea, aeb, afa, afb, porta_output_ready, portb_output_ready;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int i, k;
  // ==========================================================
  // Clock, partner and design
  initial forever #25 i_clk = ~i_clk;
  bfro_port_clk i_bfro_port_clk (.i_clk(i_clk), .o_porta_clock(pclk[0]), .o_portb_clock(pclk[1]));
  bfro_top i_bfro_top (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_porta_clock(pclk[0]), .i_portb_clock(pclk[1]),
    .i_fifo_one_reset_n(rst_n[0]), .i_fifo_two_reset_n(rst_n[1]), .i_flag_select_lo(fs[0]),
    .i_flag_select_hi(fs[1]), .i_porta_chip_select_n(ctl[0].cs_n), .i_porta_write_read_sel(ctl[0].wr_sel),
    .i_porta_enable(ctl[0].en), .i_porta_mailbox_sel(ctl[0].mb_sel), .i_portb_chip_select_n(ctl[1].cs_n),
    .i_portb_write_read_sel(ctl[1].wr_sel), .i_portb_enable(ctl[1].en), .i_portb_mailbox_sel(ctl[1].mb_sel),
    .i_porta_data_bus(oe[0] ? dout[0] : din[0]), .i_portb_data_bus(oe[1] ? dout[1] : din[1]),
    .o_porta_data_bus(dout[0]), .o_porta_data_bus_oe(oe[0]), .o_portb_data_bus(dout[1]),
    .o_portb_data_bus_oe(oe[1]), .o_porta_input_ready(ir[0]), .o_porta_output_ready(porta_output_ready),
    .o_porta_almost_empty_n(aea), .o_porta_almost_full_n(afa), .o_portb_input_ready(ir[1]),
    .o_portb_output_ready(portb_output_ready), .o_portb_almost_empty_n(aeb), .o_portb_almost_full_n(afb),
    .o_mailbox_one_flag_n(mbf[0]), .o_mailbox_two_flag_n(mbf[1]));
  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // One op on port s, held across its port clock edge
  task automatic port_op(input int s, input logic [3:0] c, input logic [35:0] d);
    @(negedge pclk[s]);
    idle(1);
    ctl[s] = c;
    din[s] = d;
    @(posedge pclk[s]);
    idle(4);
    ctl[s].en = 1'b0;
  endtask
  task automatic wait_ir(input int s);
    int n;
    for (n = 0; n < 400 && ir[s] !== 1'b1; n++) @(posedge i_clk);
    #1;
  endtask
  // Mail from port s shown and read at the far port
  task automatic mail(input int s, input logic [35:0] d);
    int t;
    t = 1 - s;
    ctl[t] = OP_MB[s] & 4'hd;
    port_op(s, OP_MB[s], d);
    idle(6);
    chk("mail flag", mbf[s], 1'b0);
    chk("mail out", dout[t], d);
    if (s == 0) begin
      ctl[1].mb_sel = 1'b0;
      idle(6);
      chk("queue out", dout[1], 36'ha_0000_0001);
    end
    port_op(t, OP_MB[s], 36'h0);
    idle(6);
    chk("mail flag read", mbf[s], 1'b1);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    idle(3);
    i_arst_n = 1'b1;
    idle(2);
    chk("a oe after reset", oe[0], 1'b0);
    idle(48);
    rst_n = 2'h3;
    wait_ir(0);
    chk("a ready", ir[0], 1'b1);
    for (i = 0; i < 4; i++) begin
      chk("b ready early", ir[1], 1'b0);
      port_op(0, 4'h6, OFS[i]);
    end
    wait_ir(1);
    chk("b ready", ir[1], 1'b1);
    for (i = 1; i < 6; i++) begin
      port_op(0, 4'h6, 36'ha_0000_0000 + 36'(i));
      idle(40);
      if (i == 3) chk("b almost empty", aeb, 1'b0);
      if (i == 4) chk("b almost empty", aeb, 1'b1);
      if (i == 4) chk("a almost full", afa, 1'b1);
      if (i == 5) chk("a almost full", afa, 1'b0);
    end
    ctl[1] = 4'h4;
    idle(6);
    chk("b oe", oe[1], 1'b1);
    chk("a oe", oe[0], 1'b0);
    chk("b word", dout[1], 36'ha_0000_0001);
    chk("b out ready", portb_output_ready, 1'b1);
    $display("test programming done");
    mail(0, 36'h1_2345_6789);
    mail(1, 36'h9_8765_4321);
    $display("test mailbox done");
    for (i = 0; i < 3; i++) begin
      rst_n = 2'h0;
      idle(50);
      chk("a empty forced", aea, 1'b0);
      chk("b full forced", afb, 1'b1);
      chk("mail two forced", mbf[1], 1'b1);
      chk("b ready forced", ir[1], 1'b0);
      chk("a out ready", porta_output_ready, 1'b0);
      chk("b out ready forced", portb_output_ready, 1'b0);
      fs = FSEL[i];
      idle(1);
      rst_n = 2'h3;
      idle(4);
      fs = 2'h0;
      wait_ir(1);
      chk("b ready", ir[1], 1'b1);
      for (k = 0; k <= PRE[i]; k++) port_op(1, 4'h2, 36'(k));
      idle(40);
      chk("a almost empty", aea, 1'b0);
      port_op(1, 4'h2, 36'h0);
      idle(40);
      chk("a almost empty", aea, 1'b1);
    end
    $display("test presets done");
    print_verdict();
  end
endmodule
